// >>> common/drsp_consts.vh
// Constants for the dual rheostat serial port: word layout, commands,
// storage map and reset values.
// Assumes a 100 MHz system clock sampling a slow serial link.
//
// Overview of operation
// - 24-bit command word, MSB first
// - Fields: 4 command, 4 address, 16 data
// - Address bit zero picks wiper channel
// - Locations 2-14 user, 15 read-only
// - Command 11 loads ten data bits
// - Command 3 stores sixteen bits
// - Commands 10/9 read wiper/store out
// - Otherwise output passes stream for chaining
// - Output only pulls low or releases
// - Output released while select high
// - Select rising edge executes held word
// - Modes 0,0 and 1,1 both work
// - Power-on copies stored values to wipers
// - Wiper code decoded one-hot, 1024 taps
// - Code zero is B end tap
// - Restore on commands 1, 8, preset pulse
// - Write protect blocks wiper changes, not restores
// - Commands 14/15 increment one/both wipers
// - Doubling: 0 to 1, midscale up saturates
`ifndef DRSP_CONSTS_VH
`define DRSP_CONSTS_VH

`define DRSP_WORD_BITS    24
`define DRSP_CMD_MSB      23
`define DRSP_CMD_LSB      20
`define DRSP_ADR_MSB      19
`define DRSP_ADR_LSB      16
`define DRSP_DAT_MSB      15
`define DRSP_DAT_LSB      0
`define DRSP_WIPER_BITS   10
`define DRSP_TAPS         1024

`define DRSP_CMD_NOP      4'h0
`define DRSP_CMD_RESTORE  4'h1
`define DRSP_CMD_SAVE     4'h2
`define DRSP_CMD_STORE    4'h3
`define DRSP_CMD_DEC6     4'h4
`define DRSP_CMD_DEC6_ALL 4'h5
`define DRSP_CMD_DEC      4'h6
`define DRSP_CMD_DEC_ALL  4'h7
`define DRSP_CMD_RST_ALL  4'h8
`define DRSP_CMD_RD_STORE 4'h9
`define DRSP_CMD_RD_WIPER 4'hA
`define DRSP_CMD_WR_WIPER 4'hB
`define DRSP_CMD_INC6     4'hC
`define DRSP_CMD_INC6_ALL 4'hD
`define DRSP_CMD_INC      4'hE
`define DRSP_CMD_INC_ALL  4'hF

`define DRSP_ADR_USER_LO  4'h2
`define DRSP_ADR_USER_HI  4'hE
`define DRSP_ADR_FACTORY  4'hF

`define DRSP_WIPER_FULL   10'h3FF
`define DRSP_WIPER_MID    10'h200
`define DRSP_WIPER_ONE    10'h001
`define DRSP_STORE_RESET  16'h0000
`define DRSP_FACTORY_VAL  16'h0000

`endif

// >>> src/drsp_serial_port.v
// Serial command front end of a dual 1024-position rheostat.
// Assumes serial_clk, serial_in, select_n, preset_n, protect_n are
// asynchronous pins; each passes two flip-flops before use.
`default_nettype none
`include "drsp_consts.vh"

module drsp_serial_port
(
    input  wire         sys_clk,
    input  wire         reset_n,
    input  wire         serial_clk,
    input  wire         serial_in,
    input  wire         select_n,
    input  wire         preset_n,
    input  wire         protect_n,
    output reg          serial_out_o,
    output reg          serial_out_oe,
    output reg  [9:0]   wiper0,
    output reg  [9:0]   wiper1,
    output reg  [1023:0] tap0,
    output reg  [1023:0] tap1
);

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    reg [4:0] meta;
    reg [4:0] sync;
    reg       clk_d;
    reg       cs_d;
    reg       pr_d;

    // First stage read only by the second
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta  <= 5'h1D;
            sync  <= 5'h1D;
            clk_d <= 1'b0;
            cs_d  <= 1'b1;
            pr_d  <= 1'b1;
        end
        else
        begin
            meta  <= {protect_n, preset_n, select_n, serial_in, serial_clk};
            sync  <= meta;
            clk_d <= sync[0];
            cs_d  <= sync[2];
            pr_d  <= sync[3];
        end
    end

    wire s_clk  = sync[0];
    wire s_din  = sync[1];
    wire s_cs_n = sync[2];
    wire s_pr_n = sync[3];
    wire s_wp_n = sync[4];

    // Idle level of the link clock tells the mode: low idle samples on
    // rising edges, high idle also samples on rising edges (mode 1,1).
    wire clk_rise = s_clk & ~clk_d;
    wire clk_fall = ~s_clk & clk_d;
    wire cs_rise  = s_cs_n & ~cs_d;
    wire pr_rise  = s_pr_n & ~pr_d;

    // --------------------------------------------------------------
    // Shift register and readback
    // --------------------------------------------------------------
    reg [23:0] shreg;
    reg [23:0] rdback;
    reg        rd_armed;
    reg        out_bit;

    wire [3:0]  cmd  = shreg[`DRSP_CMD_MSB:`DRSP_CMD_LSB];
    wire [3:0]  adr  = shreg[`DRSP_ADR_MSB:`DRSP_ADR_LSB];
    wire [15:0] dat  = shreg[`DRSP_DAT_MSB:`DRSP_DAT_LSB];
    wire        chan = adr[0];

    wire [15:0] st_rd;
    wire [15:0] st_c0;
    wire [15:0] st_c1;
    reg         st_we;
    reg  [3:0]  st_wa;
    reg  [15:0] st_wd;
    reg  [1:0]  rd_pend;

    // MSB first in on rises; output on falls, or at select fall in mode 0
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            shreg   <= 24'h000000;
            out_bit <= 1'b1;
        end
        else if (!s_cs_n)
        begin
            if (clk_rise)
                shreg <= {shreg[22:0], s_din};
            if (clk_fall || (cs_d && !s_clk))
                out_bit <= rd_armed ? rdback[23] : shreg[23];
        end
    end

    // Readback word shifted out during the next frame
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            rdback   <= 24'h000000;
            rd_armed <= 1'b0;
        end
        else if (rd_pend == 2'd2)
        begin
            rdback   <= {shreg[23:16], st_rd};
            rd_armed <= 1'b1;
        end
        else if (rd_pend == 2'd3)
        begin
            rdback   <= {shreg[23:16], 6'h00, chan ? wiper1 : wiper0};
            rd_armed <= 1'b1;
        end
        else if (!s_cs_n && rd_armed && (clk_fall || (cs_d && !s_clk)))
            rdback <= {rdback[22:0], 1'b0};
        else if (cs_rise)
            rd_armed <= 1'b0;
    end

    // Open drain: pull low only, released while deselected
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            serial_out_o  <= 1'b0;
            serial_out_oe <= 1'b0;
        end
        else
        begin
            serial_out_o  <= 1'b0;
            serial_out_oe <= ~s_cs_n & ~out_bit;
        end
    end

    // --------------------------------------------------------------
    // Command execution
    // --------------------------------------------------------------
    function [9:0] dbl;
        input [9:0] v;
        begin
            if (v == 10'h000)
                dbl = `DRSP_WIPER_ONE;
            else if (v >= `DRSP_WIPER_MID)
                dbl = `DRSP_WIPER_FULL;
            else
                dbl = {v[8:0], 1'b0};
        end
    endfunction

    function [9:0] inc;
        input [9:0] v;
        begin
            inc = (v == `DRSP_WIPER_FULL) ? v : v + 10'd1;
        end
    endfunction

    function [9:0] dec;
        input [9:0] v;
        begin
            dec = (v == 10'h000) ? v : v - 10'd1;
        end
    endfunction

    reg       pwr_restore;
    reg [1:0] restore;   // bit0 ch0, bit1 ch1, taken one cycle later
    wire      wp = ~s_wp_n;

    // Execute on chip-select rising edge
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wiper0      <= 10'h000;
            wiper1      <= 10'h000;
            st_we       <= 1'b0;
            st_wa       <= 4'h0;
            st_wd       <= 16'h0000;
            rd_pend     <= 2'd0;
            restore     <= 2'b00;
            pwr_restore <= 1'b1;
        end
        else
        begin
            st_we   <= 1'b0;
            rd_pend <= (rd_pend == 2'd1) ? 2'd2 : 2'd0;
            // Store read data lags a cycle; restore uses it then
            if (restore[0])
                wiper0 <= st_c0[9:0];
            if (restore[1])
                wiper1 <= st_c1[9:0];
            restore     <= {pwr_restore, pwr_restore};
            pwr_restore <= 1'b0;
            if (pr_rise)
                restore <= 2'b11;
            if (cs_rise)
            begin
                case (cmd)
                `DRSP_CMD_RESTORE:
                    restore <= (chan ? 2'b10 : 2'b01) | {pr_rise, pr_rise};
                `DRSP_CMD_RST_ALL:
                    restore <= 2'b11;
                `DRSP_CMD_SAVE:
                begin
                    st_we <= 1'b1;
                    st_wa <= {3'b000, chan};
                    st_wd <= {6'h00, chan ? wiper1 : wiper0};
                end
                `DRSP_CMD_STORE:
                begin
                    st_we <= (adr != `DRSP_ADR_FACTORY);
                    st_wa <= adr;
                    st_wd <= dat;
                end
                `DRSP_CMD_RD_STORE:
                    rd_pend <= 2'd1;
                `DRSP_CMD_RD_WIPER:
                    rd_pend <= 2'd3;
                `DRSP_CMD_WR_WIPER:
                    if (!wp)
                    begin
                        if (chan)
                            wiper1 <= dat[9:0];
                        else
                            wiper0 <= dat[9:0];
                    end
                `DRSP_CMD_INC, `DRSP_CMD_DEC, `DRSP_CMD_INC6, `DRSP_CMD_DEC6:
                    if (!wp)
                    begin
                        if (chan)
                            wiper1 <= step(cmd, wiper1);
                        else
                            wiper0 <= step(cmd, wiper0);
                    end
                `DRSP_CMD_INC_ALL, `DRSP_CMD_DEC_ALL,
                `DRSP_CMD_INC6_ALL, `DRSP_CMD_DEC6_ALL:
                    if (!wp)
                    begin
                        wiper0 <= step(cmd, wiper0);
                        wiper1 <= step(cmd, wiper1);
                    end
                default:
                    st_we <= 1'b0;
                endcase
            end
        end
    end

    // Single and gang variants share one step function
    function [9:0] step;
        input [3:0] c;
        input [9:0] v;
        begin
            case (c)
            `DRSP_CMD_INC, `DRSP_CMD_INC_ALL:   step = inc(v);
            `DRSP_CMD_DEC, `DRSP_CMD_DEC_ALL:   step = dec(v);
            `DRSP_CMD_INC6, `DRSP_CMD_INC6_ALL: step = dbl(v);
            `DRSP_CMD_DEC6, `DRSP_CMD_DEC6_ALL: step = {1'b0, v[9:1]};
            default:                            step = v;
            endcase
        end
    endfunction

    // Read address must be valid the cycle after select rises
    wire [3:0] rd_addr = adr;

    drsp_store u_store
    (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr_en   (st_we),
        .wr_addr (st_wa),
        .wr_data (st_wd),
        .rd_addr (rd_addr),
        .rd_data (st_rd),
        .chan0   (st_c0),
        .chan1   (st_c1)
    );

    // --------------------------------------------------------------
    // Tap decode, one tap per code, tap 0 at the B end
    // --------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < `DRSP_TAPS; t = t + 1)
        begin : g_tap
            always @(posedge sys_clk)
            begin
                if (!reset_n)
                begin
                    tap0[t] <= (t == 0);
                    tap1[t] <= (t == 0);
                end
                else
                begin
                    tap0[t] <= (wiper0 == t);
                    tap1[t] <= (wiper1 == t);
                end
            end
        end
    endgenerate

endmodule // drsp_serial_port
`default_nettype wire

// >>> src/drsp_store.v
// Sixteen-word nonvolatile store model, registered read port.
// Assumes single writer on sys_clk; location 15 write guarded by caller.
`default_nettype none
`include "drsp_consts.vh"

module drsp_store
(
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        wr_en,
    input  wire [3:0]  wr_addr,
    input  wire [15:0] wr_data,
    input  wire [3:0]  rd_addr,
    output reg  [15:0] rd_data,
    output reg  [15:0] chan0,
    output reg  [15:0] chan1
);

    reg [15:0] mem [0:15];
    integer i;

    // --------------------------------------------------------------
    // Storage array
    // --------------------------------------------------------------
    // Reset stands in for factory contents so simulation starts known
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 16; i = i + 1)
                mem[i] <= `DRSP_STORE_RESET;
            mem[15] <= `DRSP_FACTORY_VAL;
        end
        else if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // Registered reads, channel words exposed for restores
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            rd_data <= 16'h0000;
            chan0   <= 16'h0000;
            chan1   <= 16'h0000;
        end
        else
        begin
            rd_data <= mem[rd_addr];
            chan0   <= mem[0];
            chan1   <= mem[1];
        end
    end

endmodule // drsp_store
`default_nettype wire

// >>> tb/drsp_host_model.sv
// Host master model: frames words onto the serial pins at 160 ns period.
// Assumes the caller sees the pulled-up output wire level.
`default_nettype none

module drsp_host_model (
    output var logic serial_clk,
    output var logic serial_in,
    output var logic select_n,
    input wire logic serial_out_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: deselected, clock still between frames
    initial
    begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        select_n = 1'b1;
    end

    // One frame, MSB first; cpol picks idle level, sampling is always rising
    task automatic xfer(input logic [47:0] w, input int n, input logic cpol,
                        output logic [47:0] got);
        got = 48'h0;
        serial_clk <= cpol;
        #83;
        select_n <= 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_clk <= 1'b0;
            serial_in <= w[i];
            #80;
            got = {got[46:0], serial_out_wire};
            serial_clk <= 1'b1;
            #80;
        end
        serial_clk <= cpol;
        #80;
        select_n <= 1'b1;
        serial_in <= ~serial_in;
        #160;
    endtask
endmodule // drsp_host_model

`default_nettype wire

// >>> tb/drsp_properties.sv
// Checker for the rheostat serial port, bound to its top module.
// Assumes only the top's ports are visible; one sys_clk domain.
`default_nettype none

module drsp_properties (
    input wire logic          sys_clk,
    input wire logic          reset_n,
    input wire logic          serial_clk,
    input wire logic          serial_in,
    input wire logic          select_n,
    input wire logic          preset_n,
    input wire logic          protect_n,
    input wire logic          serial_out_o,
    input wire logic          serial_out_oe,
    input wire logic [9:0]    wiper0,
    input wire logic [9:0]    wiper1,
    input wire logic [1023:0] tap0,
    input wire logic [1023:0] tap1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hi_cnt;
    logic [3:0] lo_cnt;
    logic [3:0] out_cnt;
    logic [3:0] exe_cnt;

    function automatic logic [3:0] sat(input logic [3:0] x);
        return (x == 4'hF) ? x : x + 4'h1;
    endfunction

    // Cycles since select, clock and execute events; saturate, never wrap
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            hi_cnt  <= 4'h0;
            lo_cnt  <= 4'h0;
            out_cnt <= 4'h0;
            exe_cnt <= 4'h0;
        end
        else
        begin
            hi_cnt  <= select_n ? sat(hi_cnt) : 4'h0;
            lo_cnt  <= select_n ? 4'h0 : sat(lo_cnt);
            out_cnt <= ($fell(serial_clk) || !$stable(select_n)) ? 4'h0 : sat(out_cnt);
            exe_cnt <= ($rose(select_n) || $rose(preset_n)) ? 4'h0 : sat(exe_cnt);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_release_idle: assert property (hi_cnt >= 4'h8 |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    a_drain_only: assert property (serial_out_oe |-> !serial_out_o)
        else $error("serial out driven high");
    a_tap_onehot: assert property ($onehot(tap0) && $onehot(tap1))
        else $error("tap select not one-hot");
    a_tap_follow: assert property (tap0 == (1024'h1 << $past(wiper0))
        && tap1 == (1024'h1 << $past(wiper1)))
        else $error("tap does not match wiper code");
    a_frame_stable: assert property (lo_cnt >= 4'h8 |-> $stable(wiper0) && $stable(wiper1))
        else $error("wiper moved inside a frame");
    a_exec_cause: assert property (!$stable(wiper0) || !$stable(wiper1) |-> exe_cnt < 4'hE)
        else $error("wiper moved without execute event");
    a_exec_late: assert property ($rose(select_n) |=>
        ($stable(wiper0) && $stable(wiper1)) [*2])
        else $error("wiper moved too soon after select");
    a_out_timing: assert property (!$stable(serial_out_oe) |-> out_cnt < 4'h9)
        else $error("serial out moved off clock edge");
endmodule // drsp_properties

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the dual rheostat serial port.
// Assumes the host model drives the link; pull-up on serial out.
`default_nettype none
`include "drsp_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic          sys_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          preset_n = 1'b1;
    logic          protect_n = 1'b1;
    wire logic     serial_clk, serial_in, select_n, serial_out_o, serial_out_oe;
    wire logic [9:0]    wiper0, wiper1;
    wire logic [1023:0] tap0, tap1;
    logic [47:0]   got;
    int            fails = 0;
    int            check_count = 0;
    logic [9:0]    dbl_in [4] = '{10'h000, 10'h200, 10'h155, 10'h1FF};
    logic [9:0]    dbl_out [4] = '{10'h001, 10'h3FF, 10'h2AA, 10'h3FE};

    always #5 sys_clk = ~sys_clk;

    drsp_serial_port u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .select_n(select_n), .preset_n(preset_n),
        .protect_n(protect_n), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
        .wiper0(wiper0), .wiper1(wiper1), .tap0(tap0), .tap1(tap1));
    drsp_host_model u_host (.serial_clk(serial_clk), .serial_in(serial_in),
        .select_n(select_n), .serial_out_wire(serial_out_oe ? serial_out_o : 1'b1));

    task automatic send(input logic [23:0] w, input logic m);
        u_host.xfer({24'h000000, w}, 24, m, got);
    endtask

    task automatic chkw(input logic [9:0] e0, input logic [9:0] e1);
        `CHK("wiper0", e0, wiper0)
        `CHK("wiper1", e1, wiper1)
        `CHK("tap0", 1024'h1 << e0, tap0)
        `CHK("tap1", 1024'h1 << e1, tap1)
    endtask

    task automatic final_report;
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog: run needs about 165 us, limit leaves room for slow frames
    initial
    begin
        #400000;
        fails++;
        final_report;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chkw(10'h000, 10'h000);
        `CHK("oe", 1'b0, serial_out_oe)
        send(24'hB00100, 1'b0);
        chkw(10'h100, 10'h000);
        send(24'hB10200, 1'b1);
        `CHK("pass", 24'hB00100, got[23:0])
        chkw(10'h100, 10'h200);
        send(24'h32AAAA, 1'b1);
        send(24'h3F1234, 1'b1);
        send(24'h920000, 1'b1);
        send(24'h000000, 1'b1);
        `CHK("rd store", 24'h92AAAA, got[23:0])
        send(24'h9F0000, 1'b1);
        send(24'h000000, 1'b1);
        `CHK("rd factory", {8'h9F, `DRSP_FACTORY_VAL}, got[23:0])
        send(24'hA10000, 1'b1);
        send(24'h000000, 1'b1);
        `CHK("rd wiper", 24'hA10200, got[23:0])
        send(24'hE00000, 1'b1);
        chkw(10'h101, 10'h200);
        send(24'hF00000, 1'b1);
        chkw(10'h102, 10'h201);
        // Doubling table: zero, midscale, below and just under midscale
        for (int i = 0; i < 4; i++)
        begin
            send({14'h2C00, dbl_in[i]}, 1'b1);
            send(24'hC00000, 1'b1);
            chkw(dbl_out[i], 10'h201);
        end
        @(posedge sys_clk) protect_n <= 1'b0;
        send(24'hB00005, 1'b1);
        send(24'hE00000, 1'b1);
        chkw(10'h3FE, 10'h201);
        send(24'h300077, 1'b1);
        send(24'h100000, 1'b1);
        chkw(10'h077, 10'h201);
        send(24'h310033, 1'b1);
        @(posedge sys_clk) preset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        preset_n <= 1'b1;
        repeat (16) @(posedge sys_clk);
        chkw(10'h077, 10'h033);
        @(posedge sys_clk) protect_n <= 1'b1;
        send(24'hB00001, 1'b1);
        send(24'hB10001, 1'b1);
        send(24'h800000, 1'b1);
        chkw(10'h077, 10'h033);
        u_host.xfer({24'hB00111, 24'hB10222}, 48, 1'b1, got);
        `CHK("chain out", 48'h800000B00111, got)
        chkw(10'h077, 10'h222);
        // Mode 0 frames: decrements, right shifts, gang doubling, save
        send(24'h600000, 1'b0);
        chkw(10'h076, 10'h222);
        send(24'h710000, 1'b0);
        chkw(10'h075, 10'h221);
        send(24'h400000, 1'b0);
        chkw(10'h03A, 10'h221);
        send(24'h510000, 1'b0);
        chkw(10'h01D, 10'h110);
        send(24'hD00000, 1'b0);
        chkw(10'h03A, 10'h220);
        send(24'h210000, 1'b0);
        send(24'h910000, 1'b0);
        `CHK("mode0 pass", 24'h210000, got[23:0])
        send(24'h000000, 1'b0);
        `CHK("mode0 rd", 24'h910220, got[23:0])
        send(24'h000000, 1'b1);
        final_report;
    end
endmodule // testbench

bind drsp_serial_port drsp_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .select_n(select_n),
    .preset_n(preset_n), .protect_n(protect_n), .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe), .wiper0(wiper0), .wiper1(wiper1), .tap0(tap0),
    .tap1(tap1));

`default_nettype wire
